// file: logic/cisr_pkg.sv
package cisr_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CISR_OFS_DIE_IDENTITY = 8'h00;
  localparam logic [7:0] CISR_OFS_SILICON_REVISION = 8'h01;
  localparam logic [7:0] CISR_OFS_CHARGER_STATE_REPORT = 8'h02;
  localparam logic [7:0] CISR_OFS_INPUT_THERMAL_REPORT = 8'h03;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  // charger_state_report layout
  localparam int CISR_POS_CHARGER_STATE = 0;
  localparam int CISR_POS_BATTERY_PRESENT = 3;
  localparam int CISR_POS_ADAPTER_KIND = 4;
  // input_thermal_report layout, bit 5 is reserved and reads zero
  localparam int CISR_POS_THERMAL_BAND = 0;
  localparam int CISR_POS_BUS_VALID = 3;
  localparam int CISR_POS_ENUMERATION_FAULT = 4;
  localparam int CISR_POS_INPUT_LIMIT = 6;
  localparam int CISR_POS_SUSPENDED = 7;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] CISR_CHG_OFF = 3'h0;
  localparam logic [2:0] CISR_CHG_TEMP_SUSPEND = 3'h1;
  localparam logic [2:0] CISR_CHG_PRECHARGE = 3'h2;
  localparam logic [2:0] CISR_CHG_FAST = 3'h3;
  localparam logic [2:0] CISR_CHG_TOPOFF = 3'h4;
  localparam logic [2:0] CISR_CHG_MAINTAIN = 3'h5;
  localparam logic [2:0] CISR_CHG_DONE = 3'h6;
  localparam logic [2:0] CISR_CHG_FAULT = 3'h7;
  localparam logic [3:0] CISR_ADAPTER_NONE = 4'h0;
  localparam logic [2:0] CISR_THERM_DISABLED = 3'h5;

  // ---------------------------------------------------------------
  // Values after reset and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] CISR_RST_BYTE = 8'h00;
  localparam logic [7:0] CISR_RST_POINTER = 8'h00;
  localparam logic [3:0] CISR_RST_BITS = 4'h0;
  localparam logic [3:0] CISR_BITS_PER_BYTE = 4'h8;

  // Live status from the charging and detection engines
  typedef struct packed {
    logic [2:0] charger_state;
    logic battery_present;
    logic [3:0] adapter_kind;
    logic [2:0] thermal_band;
    logic bus_valid;
    logic battery_above_lockout;
    logic enumeration_fault;
    logic input_limit_active;
    logic suspended;
  } cisr_status_s;

endpackage

// file: logic/cisr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cisr_sync
  import cisr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous level in, synchronous level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] stage1; // Only stage2 reads this flop
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  // Next values; idle bus level is high so reset to ones
  always_comb begin
    next_stage1 = async_in;
    next_stage2 = stage1;
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_stage2;
    end
  end

endmodule

`default_nettype wire

// file: logic/cisr_reg_mux.sv
`timescale 1ns/1ps
`default_nettype none

module cisr_reg_mux
  import cisr_pkg::*;
(
  // Selected offset and live state
  input wire logic [7:0] pointer,
  input wire cisr_status_s status,
  input wire logic [7:0] die_identity,
  input wire logic [7:0] silicon_revision,
  // Byte to shift out
  output logic [7:0] read_byte
);

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  // Built straight from live inputs: no copy is stored, so nothing to reset
  always_comb begin
    read_byte = CISR_RST_BYTE;
    unique case (pointer)
      CISR_OFS_DIE_IDENTITY: begin
        read_byte = die_identity;
      end
      CISR_OFS_SILICON_REVISION: begin
        read_byte = silicon_revision;
      end
      CISR_OFS_CHARGER_STATE_REPORT: begin
        if (status.bus_valid) begin
          read_byte[CISR_POS_CHARGER_STATE +: 3] = status.charger_state;
          read_byte[CISR_POS_BATTERY_PRESENT] = status.battery_present;
          read_byte[CISR_POS_ADAPTER_KIND +: 4] = status.adapter_kind;
        end
      end
      CISR_OFS_INPUT_THERMAL_REPORT: begin
        read_byte[CISR_POS_THERMAL_BAND +: 3] = status.thermal_band;
        read_byte[CISR_POS_BUS_VALID] = status.bus_valid;
        read_byte[CISR_POS_ENUMERATION_FAULT] = status.enumeration_fault;
        read_byte[CISR_POS_INPUT_LIMIT] = status.input_limit_active;
        read_byte[CISR_POS_SUSPENDED] = status.suspended;
      end
      // Unmapped offsets read as zero
      default: begin
        read_byte = CISR_RST_BYTE;
      end
    endcase
  end

endmodule

`default_nettype wire

// file: logic/cisr_id_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

module cisr_id_status_regs
  import cisr_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h2a, // Arbitrary neutral value
  parameter logic [7:0] DIE_IDENTITY = 8'h5a, // Arbitrary neutral value
  parameter logic [3:0] MASK_SET = 4'h3, // Arbitrary neutral value
  parameter logic [3:0] DASH_LEVEL = 4'hc // Arbitrary neutral value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial bus clock pin
  input wire logic scl_in,
  // Serial bus data pin, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Live state from charging and detection engines
  input wire cisr_status_s status
);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  // One-hot: a single flop per phase keeps the decode shallow
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, // Waiting for a start condition
    ST_ADDR = 9'h002, // Shifting in address and direction
    ST_ADDR_ACK = 9'h004, // Acknowledging our address
    ST_PTR = 9'h008, // Shifting in register offset
    ST_PTR_ACK = 9'h010, // Acknowledging the offset
    ST_WR_DATA = 9'h020, // Shifting in write data, discarded
    ST_WR_ACK = 9'h040, // Acknowledging discarded data
    ST_RD_DATA = 9'h080, // Shifting out a register byte
    ST_RD_ACK = 9'h100 // Sampling master acknowledge
  } cisr_state_e;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic scl_s; // Synchronised clock pin
  logic sda_s; // Synchronised data pin
  logic scl_d; // Previous synchronised clock
  logic sda_d; // Previous synchronised data

  // Bus pins arrive from outside the clock domain
  // Both pins share one synchroniser so their relative timing is kept;
  // a start or stop is judged on the pair, and a skew of one clock between
  // them would turn a data change next to a clock edge into a false condition.
  // The price is two clocks of latency on every pin edge, which the
  // four-clock minimum on each clock phase absorbs.
  cisr_sync #(.WIDTH(2)) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  // ---------------------------------------------------------------
  // Pin history
  // ---------------------------------------------------------------
  logic next_scl_d; // Clock level seen one edge later
  logic next_sda_d; // Data level seen one edge later

  // Next values: one clock of history is enough to find every edge
  always_comb begin
    next_scl_d = scl_s;
    next_sda_d = sda_s;
  end

  // History registers; idle level after reset, so no false edge follows it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Both pins idle high on a free bus
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
    end
  end

  // ---------------------------------------------------------------
  // Bus events
  // ---------------------------------------------------------------
  logic scl_rise; // Data sampling edge
  logic scl_fall; // Data change edge
  logic start_seen; // Data falls while clock high
  logic stop_seen; // Data rises while clock high
  logic access_any; // Interface powered at all
  logic [7:0] read_byte; // Byte at the current pointer

  // Edge and condition detection on synchronised copies only
  // The clock must be high on two samples in a row, so a one-clock glitch
  // on the clock pin never counts as a start or a stop
  always_comb begin
    scl_rise = scl_s && !scl_d;
    scl_fall = !scl_s && scl_d;
    start_seen = scl_s && scl_d && sda_d && !sda_s;
    stop_seen = scl_s && scl_d && !sda_d && sda_s;
  end

  // A dead interface stays silent; the host sees a refused address
  // interface alive on bus or battery
  always_comb begin
    access_any = status.bus_valid || status.battery_above_lockout;
  end

  // ---------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------
  logic [7:0] pointer; // Register offset, auto-increments on reads

  // No register copy is kept between reads: the byte is picked from the
  // live status when it is loaded into the shifter, so the host never reads
  // stale state. A field that changes while a byte is shifting shows up
  // only in the next byte, never split across one.
  // reads return live state
  cisr_reg_mux u_reg_mux (
    .pointer(pointer),
    .status(status),
    .die_identity(DIE_IDENTITY),
    .silicon_revision({DASH_LEVEL, MASK_SET}),
    .read_byte(read_byte)
  );

  // ---------------------------------------------------------------
  // Protocol state
  // ---------------------------------------------------------------
  cisr_state_e state; // Protocol phase
  cisr_state_e next_state;
  // Both directions share one shifter: a byte is never in flight both ways
  logic [7:0] shifter; // Shift register in both directions
  logic [7:0] next_shifter;
  logic [3:0] bits; // Bits moved in this byte
  logic [3:0] next_bits;
  logic [7:0] next_pointer; // Offset after this edge
  logic read_dir; // Direction bit of the address byte
  logic next_read_dir;
  logic master_ack; // Master asked for another byte
  logic next_master_ack;
  logic next_sda_oe;
  logic next_sda_out;

  // Next values of the protocol engine
  // Start and stop are checked ahead of the phase decode: the host may
  // break off any transfer with either, and the engine must follow it
  // from whatever phase it was in. The data line only moves after a clock
  // fall, so the host never sees it change while it samples.
  always_comb begin
    next_state = state;
    next_shifter = shifter;
    next_bits = bits;
    next_pointer = pointer;
    next_read_dir = read_dir;
    next_master_ack = master_ack;
    next_sda_oe = sda_oe;
    next_sda_out = 1'b0; // Open drain: only ever pulls low
    if (start_seen) begin
      // Start or repeated start restarts address phase
      next_state = ST_ADDR;
      next_bits = CISR_RST_BITS;
      next_sda_oe = 1'b0;
    end else if (stop_seen) begin
      // Stop ends any transfer and frees the line
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Silent until a start condition
          next_sda_oe = 1'b0;
        end
        // Receiving phases share the shifter
        ST_ADDR, ST_PTR, ST_WR_DATA: begin
          if (scl_rise) begin
            // Data is stable while the clock is high
            next_shifter = {shifter[6:0], sda_s};
            next_bits = bits + 4'h1;
          end else if (scl_fall && bits == CISR_BITS_PER_BYTE) begin
            // Eighth bit done: decide on the acknowledge
            next_bits = CISR_RST_BITS;
            if (state == ST_ADDR) begin
              // no answer when unpowered or other address
              if (shifter[7:1] == DEVICE_ADDRESS && access_any) begin
                next_state = ST_ADDR_ACK;
                next_read_dir = shifter[0];
                next_sda_oe = 1'b1;
              end else begin
                next_state = ST_IDLE;
              end
            end else if (state == ST_PTR) begin
              // Offset byte is latched whatever its value
              next_state = ST_PTR_ACK;
              next_pointer = shifter;
              next_sda_oe = 1'b1;
            end else begin
              next_state = ST_WR_ACK;
              next_sda_oe = 1'b1;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (read_dir) begin
              // First read byte from the stored pointer
              next_state = ST_RD_DATA;
              next_shifter = read_byte;
              next_sda_oe = !read_byte[7];
            end else begin
              // Write direction: the offset byte follows
              next_state = ST_PTR;
              next_sda_oe = 1'b0;
            end
          end
        end
        ST_PTR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            next_state = ST_WR_DATA;
            next_sda_oe = 1'b0;
          end
        end
        ST_RD_DATA: begin
          if (scl_rise) begin
            // Count the bit that the host has just sampled
            next_bits = bits + 4'h1;
          end else if (scl_fall) begin
            if (bits == CISR_BITS_PER_BYTE) begin
              // Release the line for the master acknowledge
              next_state = ST_RD_ACK;
              next_bits = CISR_RST_BITS;
              next_pointer = pointer + 8'h01;
              next_sda_oe = 1'b0;
            end else begin
              // Present the next bit while the clock is low
              next_shifter = {shifter[6:0], 1'b0};
              next_sda_oe = !shifter[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            // Low on the line means the host wants more
            next_master_ack = !sda_s;
          end else if (scl_fall) begin
            if (master_ack) begin
              // Sampled at this edge, so the byte is the latest state
              next_state = ST_RD_DATA;
              next_shifter = read_byte;
              next_sda_oe = !read_byte[7];
            end else begin
              // Not acknowledged: wait for stop or start
              next_state = ST_IDLE;
              next_sda_oe = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Registers of the protocol engine and pin drivers
  // Pin drivers are registered so the line never glitches on a decode change
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      shifter <= CISR_RST_BYTE;
      bits <= CISR_RST_BITS;
      pointer <= CISR_RST_POINTER;
      read_dir <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      state <= next_state;
      shifter <= next_shifter;
      bits <= next_bits;
      pointer <= next_pointer;
      read_dir <= next_read_dir;
      master_ack <= next_master_ack;
      sda_oe <= next_sda_oe;
      sda_out <= next_sda_out;
    end
  end

endmodule

`default_nettype wire

// file: testbench/cisr_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Serial data driver checks
// --------------------------------
module cisr_regs_props
  import cisr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Live state
  input wire cisr_status_s status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Clock seen falling
  sequence scl_fall;
    scl_in ##1 !scl_in;
  endsequence
  // Clock high long enough to rule out a recent fall
  sequence scl_settled;
    scl_in [*6];
  endsequence
  // Neither supply powers the interface
  sequence unpowered;
    (!status.bus_valid && !status.battery_above_lockout) [*8];
  endsequence
  drive_low_a: assert property (sda_oe |-> !sda_out)
    else $error("data pin driven high");
  // Drive only moves a few clocks after a clock fall, never while it is high
  oe_after_fall_a: assert property (
    $changed(sda_oe) |-> !scl_in &&
    ($past(scl_in, 3) || $past(scl_in, 4) || $past(scl_in, 5) || $past(scl_in, 6)))
    else $error("data drive changed away from a clock fall");
  oe_fall_wait_a: assert property (scl_fall |=> $stable(sda_oe) [*2])
    else $error("data drive moved too soon after clock fall");
  oe_high_steady_a: assert property (scl_settled |-> $stable(sda_oe))
    else $error("data drive moved while clock high");
  ack_holds_a: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("data drive released too early");
  reset_quiet_a: assert property ($rose(reset_n) |-> !sda_oe [*3])
    else $error("data pin driven after reset");
  // An unpowered interface never answers
  no_ack_off_a: assert property (unpowered |-> !sda_oe)
    else $error("answer while interface unpowered");
  clk_free_a: assert property (scl_fall ##1 !scl_in |-> !$rose(sda_oe))
    else $error("drive rose too soon after clock fall");
endmodule

bind cisr_id_status_regs cisr_regs_props chk (.clk(clk), .reset_n(reset_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .status(status));
`default_nettype wire

// file: testbench/cisr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Host bus master model
// --------------------------------
module cisr_host_model #(
  parameter logic [6:0] ADDR = 7'h2a // Arbitrary, matches the device
) (
  // Clock
  input wire logic clk,
  // Line level and master drivers, SDA is open drain
  input wire logic sda_in,
  output logic scl,
  output logic sda_pull
);
  int half = 8; // Clocks per clock high phase, low phase two more, raised for a slow host
  // Bus idles high, clock stands still outside frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Move only just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit; data moves two clocks after the fall so it never races the clock
  task automatic bit_x(input logic b, output logic s);
    tick(2);
    sda_pull = !b;
    tick(half);
    scl = 1'b1;
    tick(half / 2);
    s = sda_in;
    tick(half - half / 2);
    scl = 1'b0;
  endtask
  // Byte out MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(a_in, s);
    ack = !s;
  endtask
  // Start or repeated start
  task automatic start_c();
    tick(2);
    sda_pull = 1'b0;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_pull = 1'b1;
    tick(half);
    scl = 1'b0;
  endtask
  // Stop, leaves the bus idle
  task automatic stop_c();
    tick(2);
    sda_pull = 1'b1;
    tick(half);
    scl = 1'b1;
    tick(half);
    sda_pull = 1'b0;
    tick(half);
  endtask
  // Set pointer, then write one byte or read two with Sr
  task automatic access(input logic [7:0] p, input logic wr, input logic [7:0] wd,
                        output logic [15:0] rd, output logic ack);
    logic a0;
    logic a1;
    logic [7:0] q;
    start_c();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    ack = a0 && a1;
    if (wr) begin
      xfer(wd, 1'b1, q, a0);
    end else begin
      start_c();
      xfer({ADDR, 1'b1}, 1'b1, q, a0);
      xfer(8'hff, 1'b0, rd[15:8], a1);
      xfer(8'hff, 1'b1, rd[7:0], a1);
    end
    ack = ack && a0;
    stop_c();
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_charger_id_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Register bank bench
// --------------------------------
module tb_charger_id_status_regs;
  import cisr_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a; // Arbitrary value
  localparam logic [7:0] ID = 8'h5a; // Arbitrary value
  localparam logic [3:0] MS = 4'h3; // Arbitrary value
  localparam logic [3:0] DL = 4'hc; // Arbitrary value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sda_out;
  logic sda_oe;
  logic scl;
  logic sda_pull;
  wire logic sda_line;
  cisr_status_s status = '0;
  int seed = 61858;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] r;
  logic [15:0] got;
  logic ack;
  always #2.5 clk = ~clk;
  // Pulled-up line, low while either party pulls
  assign sda_line = !(sda_oe || sda_pull);
  cisr_id_status_regs #(.DEVICE_ADDRESS(ADDR), .DIE_IDENTITY(ID), .MASK_SET(MS),
    .DASH_LEVEL(DL)) uut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .status(status));
  cisr_host_model #(.ADDR(ADDR)) host (.clk(clk), .sda_in(sda_line), .scl(scl),
    .sda_pull(sda_pull));
  // Expected byte at an offset; charger state report gated by the bus flag
  function automatic logic [7:0] exp_byte(input logic [7:0] p, input cisr_status_s s);
    case (p)
      8'h00: return ID;
      8'h01: return {DL, MS};
      8'h02: return s.bus_valid ? {s.adapter_kind, s.battery_present, s.charger_state} : 8'h00;
      8'h03: return {s.suspended, s.input_limit_active, 1'b0, s.enumeration_fault,
                     s.bus_valid, s.thermal_band};
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Two-byte read; the pointer steps on to the next offset
  task automatic rd(input logic [7:0] p);
    logic pw;
    pw = status.bus_valid || status.battery_above_lockout;
    host.access(p, 1'b0, 8'h00, got, ack);
    check("ack", {15'h0, ack}, {15'h0, pw});
    if (pw) begin
      check("data", got, {exp_byte(p, status), exp_byte(p + 8'h01, status)});
    end
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    // Every state and band code, adapter kinds from a table for the first three, then random
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      status = r[15:0];
      status.charger_state = i[2:0];
      status.thermal_band = i[2:0];
      status.adapter_kind = (i < 3) ? (i == 0 ? 4'h0 : (i == 1 ? 4'h3 : 4'hc)) : r[19:16];
      status.bus_valid = 1'b1;
      rd(8'h02);
    end
    $display("test codes done");
    rd(8'h00);
    // Writes are acknowledged but change nothing
    host.access(8'h00, 1'b1, 8'hff, got, ack);
    check("write ack", {15'h0, ack}, 16'h0001);
    rd(8'h00);
    $display("test identity done");
    // Random offsets including unmapped ones, supply flags random
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      status = r[15:0];
      rd({5'h00, r[18:16]});
    end
    $display("test random done");
    status.bus_valid = 1'b0;
    status.battery_above_lockout = 1'b0;
    rd(8'h03);
    status.battery_above_lockout = 1'b1;
    rd(8'h02);
    $display("test supply done");
    // Slow host, then a reset in mid-run
    host.half = 40;
    rd(8'h03);
    host.half = 8;
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rd(8'h01);
    $display("test slow and reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
